// ==== logic/hsf_framer.v ====
// bit-oriented serial framer with crc, bit stuffing, address filter and timer
// Functional notes
// - check value is ones complement of remainder under the selected 8, 16 or 32-bit polynomial
// - transmit checksum preset to ones, divided over data, complement sent
// - receive checksum over data plus check field equals fixed 8, 16 or 32-bit residue of the selected mode
// - data inversion flips every line bit at the core boundary
// - clock inversion moves sampling and launch edge from falling to rising
// - timer clocked from one of three sources (fourth code reserved), one-shot or auto-reload
// - timer control word is 32 bits: three control, 29 count
// - timer raises its expired event on expiry
// - timer-paced mode sends exactly one frame per expiry
// - repeat command resends each expiry; normal commands queue up to 256
// - expiry with no queued frame does nothing
// - insert zero after five ones; receiver deletes it
// - optional one inserted after seven zeros and deleted on receive
// - frames bounded by flag 0x7e; receiver hunts for it continuously
// - one shared flag closes one frame and opens the next
// - optional 8 or 16-bit address check; mismatch drops frame, hunts again
// - set mask bits always match; all-zero mask disables masking
// - second maskable group address; either match accepts frame
// - address bytes optionally pushed as first bytes of frame
// - reception starts right after the opening flag
// - stop on closing flag, reset command, length limit or abort
// - after stop hunt again, close block, check crc, append status word
// - check field always sent highest coefficient first
// - 16-bit ccitt residue is fixed pattern with ones preset
`timescale 1ns/1ps
`include "hsf_defines.vh"
module hsf_framer (
    input wire core_clk,
    input wire nrst,
    input wire rx_clk_pin,
    input wire rx_data_pin,
    input wire tx_clk_pin,
    input wire rx_data_invert,
    input wire tx_data_invert,
    input wire tx_clock_out_invert,
    input wire tx_clock_in_invert,
    input wire rx_clock_invert,
    input wire [1:0] crc_mode,
    input wire one_insert_en,
    input wire [1:0] addr_mode,
    input wire addr_store_en,
    input wire [15:0] station_addr,
    input wire [15:0] station_mask,
    input wire [15:0] group_addr,
    input wire [15:0] group_mask,
    input wire rlc_en,
    input wire [15:0] receive_length_limit,
    input wire rx_reset_cmd,
    input wire [31:0] timer_ctrl,
    input wire timer_start,
    input wire timer_tx_mode,
    input wire transmit_frame_cmd,
    input wire repeat_transmit_cmd,
    input wire [7:0] tx_data,
    input wire tx_valid,
    input wire tx_last,
    output reg tx_line_q,
    output reg tx_clk_out_q,
    output reg tx_ready_q,
    output reg tx_frame_start_q,
    output reg tx_repeat_q,
    output reg [8:0] tx_frames_queued_q,
    output reg [7:0] rx_byte_q,
    output reg rx_byte_valid_q,
    output reg rx_status_flag_q,
    output reg rx_in_frame_q,
    output reg timer_expired_event_q
);
    localparam TX_FLAG = 2'h0, TX_DATA = 2'h1, TX_CRC = 2'h2;
    reg [31:0] residue, poly, kmask;
    reg [4:0] crc_last;
    reg [15:0] min_bytes;

    // ------------------------------------------------------------
    // crc helpers
    // ------------------------------------------------------------
    // width follows crc_mode through poly, kmask and crc_last
    function [31:0] crc_step;
        input [31:0] c;
        input b;
        begin
            crc_step = ({c[30:0], 1'b0} ^ ((c[crc_last] ^ b) ? poly : 32'h0))
                       & kmask;
        end
    endfunction

    function [31:0] crc_byte;
        input [31:0] c;
        input [7:0] d;
        integer i;
        reg [31:0] t;
        begin
            t = c;
            for (i = 0; i < 8; i = i + 1) t = crc_step(t, d[i]);
            crc_byte = t;
        end
    endfunction

    function [7:0] status_word;
        input vld, ok, abt, len, rst;
        begin
            status_word = 8'h00;
            status_word[`HSF_ST_VALID] = vld;
            status_word[`HSF_ST_CRC_OK] = ok;
            status_word[`HSF_ST_ABORT] = abt;
            status_word[`HSF_ST_LEN] = len;
            status_word[`HSF_ST_RESET] = rst;
        end
    endfunction

    always @* begin
        case (crc_mode)
            `HSF_CRC_8: begin
                residue = `HSF_RES8; crc_last = `HSF_LAST8; min_bytes = `HSF_MIN8;
                poly = `HSF_POLY8; kmask = `HSF_MASK8;
            end
            `HSF_CRC_16: begin
                residue = `HSF_RES16; crc_last = `HSF_LAST16; min_bytes = `HSF_MIN16;
                poly = `HSF_POLY16; kmask = `HSF_MASK16;
            end
            `HSF_CRC_32: begin
                residue = `HSF_RES32; crc_last = `HSF_LAST32; min_bytes = `HSF_MIN32;
                poly = `HSF_POLY32; kmask = `HSF_MASK32;
            end
            default: begin
                residue = 32'h0; crc_last = `HSF_LAST8; min_bytes = `HSF_MIN_OFF;
                poly = `HSF_POLY8; kmask = `HSF_MASK8;
            end
        endcase
    end

    // ------------------------------------------------------------
    // pin synchronisers and clock edges
    // ------------------------------------------------------------
    reg rx_clk_s1_q, rx_clk_s2_q, rx_clk_s3_q;
    reg rx_dat_s1_q, rx_dat_s2_q;
    reg tx_clk_s1_q, tx_clk_s2_q, tx_clk_s3_q;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rx_clk_s1_q <= 1'b0; rx_clk_s2_q <= 1'b0; rx_clk_s3_q <= 1'b0;
            rx_dat_s1_q <= 1'b1; rx_dat_s2_q <= 1'b1;
            tx_clk_s1_q <= 1'b0; tx_clk_s2_q <= 1'b0; tx_clk_s3_q <= 1'b0;
            tx_clk_out_q <= 1'b0;
        end else begin
            rx_clk_s1_q <= rx_clk_pin; rx_clk_s2_q <= rx_clk_s1_q; rx_clk_s3_q <= rx_clk_s2_q;
            rx_dat_s1_q <= rx_data_pin; rx_dat_s2_q <= rx_dat_s1_q;
            tx_clk_s1_q <= tx_clk_pin; tx_clk_s2_q <= tx_clk_s1_q; tx_clk_s3_q <= tx_clk_s2_q;
            tx_clk_out_q <= tx_clk_s2_q ^ tx_clock_out_invert;
        end
    end
    // falling edge of the effective clock; inversion turns it into rising
    wire rx_tick = (rx_clk_s3_q ^ rx_clock_invert) & ~(rx_clk_s2_q ^ rx_clock_invert);
    wire tx_tick = (tx_clk_s3_q ^ tx_clock_in_invert) & ~(tx_clk_s2_q ^ tx_clock_in_invert);
    wire rb = rx_dat_s2_q ^ rx_data_invert;

    // ------------------------------------------------------------
    // countdown timer
    // ------------------------------------------------------------
    reg [28:0] tmr_cnt_q;
    reg tmr_run_q;
    // reserved source never counts
    wire tmr_src_tick = (timer_ctrl[`HSF_TMR_SRC] == `HSF_SRC_TX) ? tx_tick :
                        (timer_ctrl[`HSF_TMR_SRC] == `HSF_SRC_RX) ? rx_tick :
                        (timer_ctrl[`HSF_TMR_SRC] == `HSF_SRC_BUS);
    wire tmr_expire = tmr_run_q & tmr_src_tick & (tmr_cnt_q <= `HSF_TMR_ONE);
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tmr_cnt_q <= 29'h0; tmr_run_q <= 1'b0; timer_expired_event_q <= 1'b0;
        end else begin
            timer_expired_event_q <= tmr_expire;
            if (timer_start) begin
                tmr_cnt_q <= timer_ctrl[`HSF_TMR_CNT];
                tmr_run_q <= 1'b1;
            end else if (tmr_expire) begin
                tmr_cnt_q <= timer_ctrl[`HSF_TMR_CNT];
                tmr_run_q <= timer_ctrl[`HSF_TMR_CONT];
            end else if (tmr_run_q & tmr_src_tick) begin
                tmr_cnt_q <= tmr_cnt_q - `HSF_TMR_ONE;
            end
        end
    end

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    reg [1:0] tx_st_q;
    reg [4:0] tx_bit_q;
    reg [7:0] tx_sh_q;
    reg tx_last_q;
    reg [31:0] tx_crc_q;
    reg [2:0] t_ones_q, t_zeros_q;
    reg exp_pend_q;
    wire have_frame = tx_repeat_q | (tx_frames_queued_q != 9'h0);
    wire tx_go = tx_valid & (timer_tx_mode ? exp_pend_q & have_frame : have_frame);
    wire flag_end = tx_tick & (tx_st_q == TX_FLAG) & (tx_bit_q[2:0] == `HSF_BYTE_LAST);
    wire stuff_ok = (tx_st_q != TX_FLAG) | (tx_bit_q == 5'h0);
    wire ins_zero = stuff_ok & (t_ones_q == `HSF_STUFF_ONES);
    wire ins_one = stuff_ok & one_insert_en & (t_zeros_q == `HSF_INS_ZEROS);
    wire [7:0] flag_pat = `HSF_FLAG;
    wire tx_b = (tx_st_q == TX_FLAG) ? flag_pat[tx_bit_q[2:0]] :
                (tx_st_q == TX_DATA) ? tx_sh_q[tx_bit_q[2:0]] : tx_crc_q[crc_last];
    wire [31:0] tx_crc_n = crc_step(tx_crc_q, tx_b);
    wire tx_end_data = tx_tick & ~ins_zero & ~ins_one & (tx_st_q == TX_DATA)
                       & (tx_bit_q[2:0] == `HSF_BYTE_LAST) & (tx_last_q | ~tx_valid);
    wire tx_done = (tx_end_data & (crc_mode == `HSF_CRC_OFF)) | (tx_tick & ~ins_zero & ~ins_one
                   & (tx_st_q == TX_CRC) & (tx_bit_q == crc_last));
    wire q_inc = transmit_frame_cmd & (tx_frames_queued_q < `HSF_MAX_FRAMES);
    wire q_dec = tx_done & ~tx_repeat_q & (tx_frames_queued_q != 9'h0);

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_st_q <= TX_FLAG; tx_bit_q <= 5'h0; tx_sh_q <= 8'h0; tx_last_q <= 1'b0;
            tx_crc_q <= 32'h0; t_ones_q <= 3'h0; t_zeros_q <= 3'h0; exp_pend_q <= 1'b0;
            tx_line_q <= 1'b1; tx_ready_q <= 1'b0; tx_frame_start_q <= 1'b0;
            tx_repeat_q <= 1'b0; tx_frames_queued_q <= 9'h0;
        end else begin
            tx_ready_q <= 1'b0;
            tx_frame_start_q <= 1'b0;
            if (transmit_frame_cmd) tx_repeat_q <= 1'b0;
            else if (repeat_transmit_cmd) tx_repeat_q <= 1'b1;
            tx_frames_queued_q <= tx_frames_queued_q + {8'h0, q_inc} - {8'h0, q_dec};
            // a fresh expiry wins over the clear taken at the flag boundary
            if (timer_expired_event_q) exp_pend_q <= 1'b1;
            else if (flag_end & ~ins_zero & ~ins_one & (tx_go | ~have_frame))
                exp_pend_q <= 1'b0;
            if (tx_tick) begin
                if (ins_zero) begin
                    tx_line_q <= tx_data_invert;
                    t_ones_q <= 3'h0;
                    t_zeros_q <= (t_zeros_q == `HSF_INS_ZEROS) ? t_zeros_q : t_zeros_q + 3'h1;
                end else if (ins_one) begin
                    tx_line_q <= ~tx_data_invert;
                    t_zeros_q <= 3'h0;
                    t_ones_q <= 3'h1;
                end else begin
                    tx_line_q <= tx_b ^ tx_data_invert;
                    t_ones_q <= tx_b ? ((t_ones_q == `HSF_INS_ZEROS) ? t_ones_q : t_ones_q + 3'h1)
                                     : 3'h0;
                    t_zeros_q <= tx_b ? 3'h0 :
                                 ((t_zeros_q == `HSF_INS_ZEROS) ? t_zeros_q : t_zeros_q + 3'h1);
                    case (tx_st_q)
                        TX_FLAG: begin
                            // idle fill is flags, so the last one opens the frame
                            tx_bit_q <= (tx_bit_q[2:0] == `HSF_BYTE_LAST) ? 5'h0 : tx_bit_q + 5'h1;
                            if (flag_end & tx_go) begin
                                tx_st_q <= TX_DATA;
                                tx_sh_q <= tx_data;
                                tx_last_q <= tx_last;
                                tx_ready_q <= 1'b1;
                                tx_frame_start_q <= 1'b1;
                                tx_crc_q <= `HSF_MASK32;
                            end
                        end
                        TX_DATA: begin
                            tx_crc_q <= tx_crc_n;
                            tx_bit_q <= tx_bit_q + 5'h1;
                            if (tx_bit_q[2:0] == `HSF_BYTE_LAST) begin
                                tx_bit_q <= 5'h0;
                                if (tx_end_data) begin
                                    tx_st_q <= (crc_mode == `HSF_CRC_OFF) ? TX_FLAG : TX_CRC;
                                    tx_crc_q <= ~tx_crc_n;
                                end else begin
                                    tx_sh_q <= tx_data;
                                    tx_last_q <= tx_last;
                                    tx_ready_q <= 1'b1;
                                end
                            end
                        end
                        TX_CRC: begin
                            tx_crc_q <= {tx_crc_q[30:0], 1'b0};
                            tx_bit_q <= tx_bit_q + 5'h1;
                            if (tx_done) begin
                                tx_st_q <= TX_FLAG;
                                tx_bit_q <= 5'h0;
                            end
                        end
                        default: tx_st_q <= TX_FLAG;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    reg [7:0] rx_raw_q, rx_acc_q, rx_pend_q, rx_addr_h_q, hold_q;
    reg [2:0] r_ones_q, r_zeros_q, rx_cnt_q;
    reg [1:0] rx_addr_n_q;
    reg rx_pend_v_q, hold_v_q, hold_st_q;
    reg [15:0] rx_bytes_q;
    reg [31:0] rx_crc_q;
    wire [7:0] raw_n = {rb, rx_raw_q[7:1]};
    wire flag_det = (raw_n == `HSF_FLAG);
    wire abort_det = rb & (r_ones_q == `HSF_ABORT_PRE);
    wire del = (~rb & (r_ones_q == `HSF_STUFF_ONES))
             | (rb & one_insert_en & (r_zeros_q == `HSF_INS_ZEROS));
    wire [7:0] acc_n = {rb, rx_acc_q[7:1]};
    wire [31:0] crc_rel = crc_byte(rx_crc_q, rx_pend_q);
    wire [31:0] crc_fin = rx_pend_v_q ? crc_rel : rx_crc_q;
    wire [15:0] bytes_rel = rx_bytes_q + 16'h1;
    wire [15:0] bytes_fin = rx_bytes_q + {15'h0, rx_pend_v_q};
    wire crc_ok = (crc_mode == `HSF_CRC_OFF) | (crc_fin == residue);
    wire a16 = (addr_mode == `HSF_ADDR_16);
    wire [15:0] amask = a16 ? `HSF_AMASK16 : `HSF_AMASK8;
    wire [15:0] a_in = {rx_addr_h_q, rx_pend_q};
    wire a_match = ((((a_in ^ station_addr) & ~station_mask) & amask) == 16'h0)
                 | ((((a_in ^ group_addr) & ~group_mask) & amask) == 16'h0);
    wire need_h = a16 & (rx_addr_n_q == 2'h0);
    wire in_addr = (rx_addr_n_q != 2'h2);
    wire len_hit = rlc_en & (bytes_rel >= receive_length_limit);

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rx_raw_q <= 8'h0; rx_acc_q <= 8'h0; rx_pend_q <= 8'h0; rx_addr_h_q <= 8'h0;
            hold_q <= 8'h0; r_ones_q <= 3'h0; r_zeros_q <= 3'h0; rx_cnt_q <= 3'h0;
            rx_addr_n_q <= 2'h0; rx_pend_v_q <= 1'b0; hold_v_q <= 1'b0; hold_st_q <= 1'b0;
            rx_bytes_q <= 16'h0; rx_crc_q <= 32'h0; rx_in_frame_q <= 1'b0;
            rx_byte_q <= 8'h0; rx_byte_valid_q <= 1'b0; rx_status_flag_q <= 1'b0;
        end else begin
            rx_byte_valid_q <= 1'b0;
            rx_status_flag_q <= 1'b0;
            if (hold_v_q) begin
                rx_byte_q <= hold_q; rx_byte_valid_q <= 1'b1; rx_status_flag_q <= hold_st_q;
                hold_v_q <= 1'b0;
            end
            if (rx_reset_cmd) begin
                rx_in_frame_q <= 1'b0;
                rx_pend_v_q <= 1'b0;
                if (rx_in_frame_q) begin
                    rx_byte_q <= status_word(1'b0, crc_ok, 1'b0, 1'b0, 1'b1);
                    rx_byte_valid_q <= 1'b1; rx_status_flag_q <= 1'b1;
                end
            end else if (rx_tick) begin
                rx_raw_q <= raw_n;
                r_ones_q <= rb ? ((r_ones_q == `HSF_INS_ZEROS) ? r_ones_q : r_ones_q + 3'h1) : 3'h0;
                r_zeros_q <= rb ? 3'h0 :
                             ((r_zeros_q == `HSF_INS_ZEROS) ? r_zeros_q : r_zeros_q + 3'h1);
                if ((rx_in_frame_q & (abort_det | flag_det)) & ((bytes_fin != 16'h0) | abort_det)) begin
                    // close: last held byte now, status word right after
                    hold_q <= status_word(~abort_det & (rx_cnt_q == `HSF_BYTE_LAST)
                              & (bytes_fin >= min_bytes), crc_ok, abort_det, 1'b0, 1'b0);
                    hold_st_q <= 1'b1;
                    if (rx_pend_v_q) begin
                        rx_byte_q <= rx_pend_q; rx_byte_valid_q <= 1'b1;
                        hold_v_q <= 1'b1;
                    end else begin
                        rx_byte_q <= status_word(1'b0, crc_ok, abort_det, 1'b0, 1'b0);
                        rx_byte_valid_q <= 1'b1; rx_status_flag_q <= 1'b1;
                    end
                end
                if (rx_in_frame_q & abort_det) begin
                    rx_in_frame_q <= 1'b0;
                    rx_pend_v_q <= 1'b0;
                end else if (flag_det) begin
                    rx_in_frame_q <= 1'b1;
                    rx_cnt_q <= 3'h0; rx_pend_v_q <= 1'b0; rx_bytes_q <= 16'h0;
                    rx_crc_q <= `HSF_MASK32;
                    rx_addr_n_q <= (addr_mode == `HSF_ADDR_OFF) ? 2'h2 : 2'h0;
                end else if (rx_in_frame_q & ~del) begin
                    rx_acc_q <= acc_n;
                    rx_cnt_q <= rx_cnt_q + 3'h1;
                    if (rx_cnt_q == `HSF_BYTE_LAST) begin
                        // one byte of delay keeps the closing flag out of the data
                        rx_pend_q <= acc_n; rx_pend_v_q <= 1'b1;
                        if (rx_pend_v_q) begin
                            rx_crc_q <= crc_rel; rx_bytes_q <= bytes_rel;
                            if (in_addr & need_h) begin
                                rx_addr_h_q <= rx_pend_q; rx_addr_n_q <= 2'h1;
                            end else if (in_addr & ~a_match) begin
                                rx_in_frame_q <= 1'b0; rx_pend_v_q <= 1'b0;
                            end else begin
                                rx_addr_n_q <= 2'h2;
                                if (~in_addr | addr_store_en) begin
                                    rx_byte_q <= (in_addr & a16) ? rx_addr_h_q : rx_pend_q;
                                    rx_byte_valid_q <= 1'b1;
                                end
                                if (in_addr & a16 & addr_store_en) begin
                                    hold_q <= rx_pend_q; hold_st_q <= 1'b0; hold_v_q <= 1'b1;
                                end else if (len_hit) begin
                                    hold_q <= status_word(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
                                    hold_st_q <= 1'b1; hold_v_q <= 1'b1;
                                    rx_in_frame_q <= 1'b0; rx_pend_v_q <= 1'b0;
                                end
                            end
                        end
                    end
                end
            end
        end
    end
endmodule // hsf_framer

// ==== logic/hsf_defines.vh ====
// constants shared by the serial framing core
`ifndef HSF_DEFINES_VH
`define HSF_DEFINES_VH
`define HSF_FLAG 8'h7e
`define HSF_CRC_OFF 2'h0
`define HSF_CRC_8 2'h1
`define HSF_CRC_16 2'h2
`define HSF_CRC_32 2'h3
`define HSF_POLY8 32'h00000007
`define HSF_POLY16 32'h00001021
`define HSF_POLY32 32'h04c11db7
`define HSF_MASK8 32'h000000ff
`define HSF_MASK16 32'h0000ffff
`define HSF_MASK32 32'hffffffff
`define HSF_RES8 32'h000000f3
`define HSF_RES16 32'h00001d0f
`define HSF_RES32 32'hc704dd7b
`define HSF_LAST8 5'h07
`define HSF_LAST16 5'h0f
`define HSF_LAST32 5'h1f
`define HSF_MIN_OFF 16'h0001
`define HSF_MIN8 16'h0002
`define HSF_MIN16 16'h0003
`define HSF_MIN32 16'h0005
`define HSF_ADDR_OFF 2'h0
`define HSF_ADDR_16 2'h2
`define HSF_AMASK8 16'h00ff
`define HSF_AMASK16 16'hffff
`define HSF_STUFF_ONES 3'h5
`define HSF_ABORT_PRE 3'h6
`define HSF_INS_ZEROS 3'h7
`define HSF_BYTE_LAST 3'h7
`define HSF_MAX_FRAMES 9'h100
`define HSF_TMR_SRC 31:30
`define HSF_TMR_CONT 29
`define HSF_TMR_CNT 28:0
`define HSF_TMR_ONE 29'h00000001
`define HSF_SRC_TX 2'h0
`define HSF_SRC_RX 2'h1
`define HSF_SRC_BUS 2'h2
`define HSF_ST_VALID 0
`define HSF_ST_CRC_OK 1
`define HSF_ST_ABORT 2
`define HSF_ST_LEN 3
`define HSF_ST_RESET 4
`endif

// ==== tb/hsf_framer_properties.sv ====
// port-level assertions for the serial framing core
`timescale 1ns/1ps
module hsf_framer_props (
    input wire core_clk,
    input wire nrst,
    input wire tx_clk_pin,
    input wire tx_clock_out_invert,
    input wire [31:0] timer_ctrl,
    input wire timer_start,
    input wire transmit_frame_cmd,
    input wire repeat_transmit_cmd,
    input wire tx_clk_out_q,
    input wire tx_ready_q,
    input wire tx_frame_start_q,
    input wire tx_repeat_q,
    input wire [8:0] tx_frames_queued_q,
    input wire [7:0] rx_byte_q,
    input wire rx_status_flag_q,
    input wire rx_in_frame_q,
    input wire timer_expired_event_q
);
    // ----------------
    // properties
    // ----------------
    reg [2:0] up_q;
    // $past needs three clean edges after reset
    always @(posedge core_clk or negedge nrst)
        if (!nrst) up_q <= 3'h0;
        else if (up_q != 3'h7) up_q <= up_q + 3'h1;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_clk_out: assert property (up_q == 3'h7 |->
        tx_clk_out_q == ($past(tx_clk_pin, 3) ^ $past(tx_clock_out_invert))) else $error("clk out");
    a_start_ready: assert property (tx_frame_start_q |-> tx_ready_q) else $error("start");
    a_queue_max: assert property (tx_frames_queued_q <= 9'h100) else $error("queue");
    a_repeat_set: assert property (repeat_transmit_cmd && !transmit_frame_cmd |=>
        tx_repeat_q) else $error("repeat set");
    a_repeat_clear: assert property (transmit_frame_cmd |=> !tx_repeat_q)
        else $error("repeat clear");
    a_bus_expiry: assert property (timer_start && timer_ctrl == 32'h80000005 |=>
        !timer_expired_event_q [*2] ##[1:6] timer_expired_event_q) else $error("expiry");
    a_never_src: assert property ($past(timer_ctrl[31:30]) == 2'h3 &&
        timer_ctrl[31:30] == 2'h3 |-> !timer_expired_event_q) else $error("never src");
    a_abort_hunt: assert property (rx_status_flag_q && rx_byte_q[2] |->
        ##[0:2] !rx_in_frame_q) else $error("abort hunt");
    c_expiry: cover property (timer_expired_event_q);
    c_status: cover property (rx_status_flag_q);
    c_start: cover property (tx_frame_start_q);
endmodule // hsf_framer_props
bind hsf_framer hsf_framer_props u_props (.*);

// ==== tb/hsf_remote_station.sv ====
// remote station: free link clock, rx bit source, tx flag watcher
`timescale 1ns/1ps
module hsf_remote_station (
    output logic rx_clk,
    output logic rx_data,
    input wire tx_line
);
    // ----------------
    // line model
    // ----------------
    bit bits_q[$];
    logic [7:0] sh_q = 8'h00;
    int n_flag = 0;
    int n_inv = 0;
    initial begin
        rx_clk = 1'b1;
        rx_data = 1'b1;
        #137;
        forever #400 rx_clk = ~rx_clk;
    end
    // idle fill is ones; frames are queued whole, flag to flag
    always @(posedge rx_clk) rx_data <= bits_q.size() ? bits_q.pop_front() : 1'b1;
    // sample on the falling edge, the same edge the core launches from
    always @(negedge rx_clk) begin
        sh_q <= {tx_line, sh_q[7:1]};
        n_flag <= n_flag + ({tx_line, sh_q[7:1]} == 8'h7e);
        n_inv <= n_inv + ({tx_line, sh_q[7:1]} == 8'h81);
    end
endmodule // hsf_remote_station

// ==== tb/hsf_framer_test.sv ====
// self-checking bench for the serial framing core
`timescale 1ns/1ps
`include "hsf_defines.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end
module hsf_framer_test;
    // ----------------
    // bench
    // ----------------
    logic core_clk = 1'b0, nrst = 1'b0, rx_data_invert, tx_data_invert, tx_clock_out_invert;
    logic tx_clock_in_invert, rx_clock_invert, one_insert_en, addr_store_en, rlc_en;
    logic rx_reset_cmd, timer_start, timer_tx_mode, transmit_frame_cmd, repeat_transmit_cmd;
    logic tx_valid, tx_last, tx_line_q, tx_clk_out_q, tx_ready_q, tx_frame_start_q, tx_repeat_q;
    logic rx_byte_valid_q, rx_status_flag_q, rx_in_frame_q, timer_expired_event_q;
    logic [1:0] crc_mode, addr_mode;
    logic [15:0] station_addr, station_mask, group_addr, group_mask, receive_length_limit;
    logic [31:0] timer_ctrl, crc;
    logic [7:0] tx_data, rx_byte_q, fl = `HSF_FLAG;
    logic [8:0] tx_frames_queued_q, got_q[$];
    wire rx_clk_pin, rx_data_pin, tx_clk_pin;
    int error_cnt = 0, n_compared = 0, ones;
    assign tx_clk_pin = rx_clk_pin;
    hsf_framer dut_u (.*);
    hsf_remote_station far_u (.rx_clk(rx_clk_pin), .rx_data(rx_data_pin), .tx_line(tx_line_q));
    initial forever #50 core_clk = ~core_clk;
    always @(posedge core_clk) if (rx_byte_valid_q) got_q.push_back({rx_status_flag_q, rx_byte_q});
    task automatic put_bit(input logic b, input bit st);
        far_u.bits_q.push_back(b);
        ones = (st && b) ? ones + 1 : 0;
        if (ones == 5) begin far_u.bits_q.push_back(1'b0); ones = 0; end
    endtask
    task automatic put_byte(input logic [7:0] b, input bit lsb);
        logic bt;
        for (int i = 0; i < 8; i++) begin
            bt = lsb ? b[i] : b[7 - i];
            if (lsb) crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ bt) ? `HSF_POLY32 : 32'h0);
            put_bit(bt, 1'b1);
        end
    endtask
    task automatic put_flag();
        for (int i = 0; i < 8; i++) put_bit(fl[i], 1'b0);
    endtask
    // idle ones after a frame read as abort; let that status pass
    task automatic drain();
        repeat (150) @(negedge core_clk);
        got_q.delete();
    endtask
    task automatic wait_status();
        int w;
        for (w = 0; w < 4000 && !(got_q.size() && got_q[$][8]); w++) @(negedge core_clk);
        `CHK(w < 4000, 1'b1)
    endtask
    task automatic t_rx_crc(input bit bad);
        drain();
        crc = 32'hffffffff;
        put_flag();
        put_byte(8'hff, 1'b1);
        put_byte(8'h3c, 1'b1);
        crc = ~crc ^ {31'h0, bad};
        for (int k = 3; k >= 0; k--) put_byte(crc[8*k +: 8], 1'b0);
        put_flag();
        wait_status();
        `CHK(got_q.size(), 7)
        `CHK(got_q[0], 9'h0ff)
        `CHK(got_q[$][1:0], {~bad, 1'b1})
        $display("test rx crc bad=%0d done", bad);
    endtask
    task automatic t_abort();
        drain();
        put_flag();
        put_byte(8'h55, 1'b1);
        wait_status();
        `CHK(got_q[$][2], 1'b1)
        $display("test abort done");
    endtask
    task automatic t_tx_idle(input bit inv);
        int a;
        tx_data_invert = inv;
        tx_clock_out_invert = inv;
        a = inv ? far_u.n_inv : far_u.n_flag;
        repeat (200) @(negedge core_clk);
        `CHK((inv ? far_u.n_inv : far_u.n_flag) > a, 1'b1)
        $display("test tx idle inv=%0d done", inv);
    endtask
    task automatic t_timer(input logic [1:0] src, input bit exp);
        int w;
        timer_ctrl = {src, 1'b0, 29'h5};
        timer_start = 1'b1;
        @(negedge core_clk);
        timer_start = 1'b0;
        for (w = 0; w < 40 && timer_expired_event_q !== 1'b1; w++) @(negedge core_clk);
        `CHK(w < 40, exp)
        $display("test timer src=%0d done", src);
    endtask
    task automatic t_tx_frame();
        int w;
        repeat_transmit_cmd = 1'b1;
        @(negedge core_clk);
        repeat_transmit_cmd = 1'b0;
        transmit_frame_cmd = 1'b1;
        `CHK(tx_repeat_q, 1'b1)
        @(negedge core_clk);
        transmit_frame_cmd = 1'b0;
        `CHK(tx_repeat_q, 1'b0)
        `CHK(tx_frames_queued_q, 9'h001)
        {tx_valid, tx_last, tx_data} = {2'b11, 8'ha5};
        for (w = 0; w < 3000 && tx_frame_start_q !== 1'b1; w++) @(negedge core_clk);
        tx_valid = 1'b0;
        `CHK(w < 3000, 1'b1)
        $display("test tx frame done");
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog well past the longest expected run
    initial begin
        #3000000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        {rx_data_invert, tx_data_invert, tx_clock_out_invert, tx_clock_in_invert} = '0;
        {rx_clock_invert, one_insert_en, addr_store_en, rlc_en, rx_reset_cmd} = '0;
        {timer_start, timer_tx_mode, transmit_frame_cmd, repeat_transmit_cmd, tx_valid} = '0;
        {tx_last, tx_data, timer_ctrl, addr_mode, station_addr, station_mask} = '0;
        {group_addr, group_mask, receive_length_limit} = '0;
        crc_mode = `HSF_CRC_32;
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
        repeat (2) @(negedge core_clk);
        t_tx_idle(1'b0);
        t_tx_idle(1'b1);
        t_tx_idle(1'b0);
        t_rx_crc(1'b0);
        t_rx_crc(1'b1);
        t_abort();
        t_timer(`HSF_SRC_BUS, 1'b1);
        t_timer(2'h3, 1'b0);
        t_tx_frame();
        print_verdict();
    end
endmodule // hsf_framer_test
